// file: logic/itc_pkg.sv
`default_nettype none
package itc_pkg;
  // Register byte addresses on the Avalon-MM slave.
  localparam logic [4:0] ADDR_CTRL1 = 5'h00;
  localparam logic [4:0] ADDR_CTRL2 = 5'h04;
  localparam logic [4:0] ADDR_FLAGS0 = 5'h08;
  localparam logic [4:0] ADDR_ENABLE0 = 5'h0C;
  localparam logic [4:0] ADDR_PRIO = 5'h10;

  localparam logic [15:0] RESET_VAL = 16'h0000;
  localparam logic [15:0] CTRL1_MASK = 16'hFFDE;
  localparam logic [15:0] CTRL2_WR_MASK = 16'h8007;
  localparam logic [15:0] FLAGS0_MASK = 16'h7FEF;
  localparam logic [2:0] PRIO_RESET = 3'h4;

  // Control register one field positions.
  localparam int C1_NEST_DIS = 15;
  localparam int C1_OVA_FLAG = 14;
  localparam int C1_OVB_FLAG = 13;
  localparam int C1_COVA_FLAG = 12;
  localparam int C1_COVB_FLAG = 11;
  localparam int C1_OVA_TE = 10;
  localparam int C1_OVB_TE = 9;
  localparam int C1_COV_TE = 8;
  localparam int C1_SHIFT_FLAG = 7;
  localparam int C1_DIV0_FLAG = 6;
  localparam int C1_MATH_FLAG = 4;
  localparam int C1_ADDR_FLAG = 3;
  localparam int C1_STACK_FLAG = 2;
  localparam int C1_OSC_FLAG = 1;

  // Control register two field positions.
  localparam int C2_ALT_VEC = 15;
  localparam int C2_IRQ_DIS_ACT = 14;
  localparam int C2_EDGE_POL = 0;

  // Flag register zero: external input zero sits at bit 0.
  localparam int F0_EXT_ZERO = 0;

  typedef struct packed {
    logic acc_a_ovf;
    logic acc_b_ovf;
    logic acc_a_cat;
    logic acc_b_cat;
    logic bad_shift;
    logic div_zero;
    logic addr_err;
    logic stack_err;
    logic osc_fail;
  } itc_trap_ev_s;

  typedef struct packed {
    logic dc;
    logic n;
    logic ov;
    logic z;
    logic c;
  } itc_status_s;

  typedef logic [3:0][15:0] itc_wregs_t;
endpackage : itc_pkg
`default_nettype wire

// file: logic/itc_top.sv
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/100ps
`default_nettype none
// How it works
// - one-level shadow of status bits and W0-W3
// - shadows loaded by push, restored by pop
// - external input zero requests only on edges
// - polarity bit one selects falling edge
// - request and wake the core together
// - control one bit 15 disables nesting
// - bits 14, 13 flag accumulator overflow traps
// - bits 12, 11 flag catastrophic overflow traps
// - bits 10, 9 enable accumulator overflow traps
// - bit 8 enables catastrophic overflow trap
// - bit 7 flags invalid shift amount
// - bit 6 flags division by zero
// - bits 4..1 flag math, address, stack, oscillator
// - control two bit 15 selects alternate vectors
// - control two bit 14 shows disable active
// - unimplemented bits always read zero
// - flag bits 14..11 for bus, memory, conversion
// - flag bits 10..8 for serial sources
// - flag bits 7,6,5,3 for timers, compare
// - implemented bits reset to zero, priority field to 4
// - flag bits 2,1,0 compare, capture, external
// - enabled flag above core priority interrupts
module itc_top #(
  parameter int EXT_N = 3,
  parameter int PRIO_W = 3
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic [4:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [EXT_N-1:0] external_irq_inputs_i,
  input wire logic [15:0] periph_events_i,
  input wire itc_pkg::itc_trap_ev_s trap_events_i,
  input wire logic irq_disable_active_i,
  input wire logic [3:0] core_priority_i,
  input wire logic in_service_i,
  input wire logic sleep_i,
  input wire logic idle_i,
  input wire logic shadow_push_i,
  input wire logic shadow_pop_i,
  input wire itc_pkg::itc_status_s status_i,
  input wire itc_pkg::itc_wregs_t wregs_i,
  output itc_pkg::itc_status_s shadow_status_o,
  output itc_pkg::itc_wregs_t shadow_wregs_o,
  output logic shadow_restore_o,
  output logic [EXT_N-1:0] ext_edge_o,
  output logic irq_request_o,
  output logic wake_o,
  output logic alt_vector_select_o,
  output logic nesting_disable_o,
  output logic trap_pending_o
);

  generate
    if (EXT_N != 3 || PRIO_W < 1 || PRIO_W > 4)
    begin : g_check
      $error("itc_top: EXT_N must be 3 and PRIO_W 1..4");
    end
  endgenerate

  typedef struct packed {
    logic wait_n;
    logic [31:0] rdata;
    logic [15:0] ctrl1;
    logic alt_vec;
    logic [EXT_N-1:0] edge_pol;
    logic [15:0] flags0;
    logic [15:0] enable0;
    logic [PRIO_W-1:0] prio;
    logic [EXT_N-1:0] ext_prev;
    logic [EXT_N-1:0] ext_edge;
    itc_pkg::itc_status_s sh_status;
    itc_pkg::itc_wregs_t sh_wregs;
    logic restore;
    logic irq;
    logic wake;
    logic trap_pend;
  } itc_state_s;

  itc_state_s state_r;
  itc_state_s state_nxt;

  logic req;
  logic do_write;
  logic [15:0] wmask;
  logic [15:0] wdata;
  logic [EXT_N-1:0] ext_edge;
  logic [15:0] ctrl1_set;
  logic [15:0] flags0_set;
  logic [15:0] ctrl2_view;
  logic pending;
  logic ov_a_trap;
  logic ov_b_trap;
  logic cov_a_trap;
  logic cov_b_trap;

  assign req = avs_read_i | avs_write_i;
  // A write lands on the edge where the master sees waitrequest low.
  assign do_write = avs_write_i & ~state_r.wait_n;
  assign wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wdata = avs_writedata_i[15:0];

  // Edge detection on the synchronous external inputs.
  genvar gi;
  generate
    for (gi = 0; gi < EXT_N; gi++)
    begin : g_edge
      assign ext_edge[gi] = state_r.edge_pol[gi] ?
        (state_r.ext_prev[gi] & ~external_irq_inputs_i[gi]) :
        (~state_r.ext_prev[gi] & external_irq_inputs_i[gi]);
    end
  endgenerate

  // Overflow traps only raise their flags while the trap is enabled.
  assign ov_a_trap = trap_events_i.acc_a_ovf & state_r.ctrl1[itc_pkg::C1_OVA_TE];
  assign ov_b_trap = trap_events_i.acc_b_ovf & state_r.ctrl1[itc_pkg::C1_OVB_TE];
  assign cov_a_trap = trap_events_i.acc_a_cat & state_r.ctrl1[itc_pkg::C1_COV_TE];
  assign cov_b_trap = trap_events_i.acc_b_cat & state_r.ctrl1[itc_pkg::C1_COV_TE];

  always_comb
  begin
    ctrl1_set = 16'h0000;
    ctrl1_set[itc_pkg::C1_OVA_FLAG] = ov_a_trap;
    ctrl1_set[itc_pkg::C1_OVB_FLAG] = ov_b_trap;
    ctrl1_set[itc_pkg::C1_COVA_FLAG] = cov_a_trap;
    ctrl1_set[itc_pkg::C1_COVB_FLAG] = cov_b_trap;
    ctrl1_set[itc_pkg::C1_SHIFT_FLAG] = trap_events_i.bad_shift;
    ctrl1_set[itc_pkg::C1_DIV0_FLAG] = trap_events_i.div_zero;
    ctrl1_set[itc_pkg::C1_MATH_FLAG] = ov_a_trap | ov_b_trap | cov_a_trap | cov_b_trap |
      trap_events_i.bad_shift | trap_events_i.div_zero;
    ctrl1_set[itc_pkg::C1_ADDR_FLAG] = trap_events_i.addr_err;
    ctrl1_set[itc_pkg::C1_STACK_FLAG] = trap_events_i.stack_err;
    ctrl1_set[itc_pkg::C1_OSC_FLAG] = trap_events_i.osc_fail;
  end

  // Peripheral events map one-to-one onto flag positions; bit 0 belongs to
  // external input zero, so the peripheral line for it is not used.
  always_comb
  begin
    flags0_set = periph_events_i & itc_pkg::FLAGS0_MASK;
    flags0_set[itc_pkg::F0_EXT_ZERO] = ext_edge[0];
  end

  always_comb
  begin
    ctrl2_view = 16'h0000;
    ctrl2_view[itc_pkg::C2_ALT_VEC] = state_r.alt_vec;
    ctrl2_view[itc_pkg::C2_IRQ_DIS_ACT] = irq_disable_active_i;
    ctrl2_view[itc_pkg::C2_EDGE_POL +: EXT_N] = state_r.edge_pol;
  end

  // Flags are evaluated from their registered copy, so a new event is
  // seen one cycle after it was caught, at the next instruction boundary.
  // With nesting disabled no request is raised while a routine runs.
  assign pending = (|(state_r.flags0 & state_r.enable0)) &&
    ({1'b0, state_r.prio} > {1'b0, core_priority_i}) &&
    !(state_r.ctrl1[itc_pkg::C1_NEST_DIS] && in_service_i);

  always_comb
  begin
    state_nxt = state_r;

    // Bus slave: one wait cycle, then a single cycle with waitrequest low.
    state_nxt.wait_n = ~(req & state_r.wait_n);
    if (req && state_r.wait_n)
    begin
      state_nxt.rdata = 32'h0000_0000;
      if (avs_read_i)
      begin
        unique case (avs_address_i)
          itc_pkg::ADDR_CTRL1: state_nxt.rdata[15:0] = state_r.ctrl1 & itc_pkg::CTRL1_MASK;
          itc_pkg::ADDR_CTRL2: state_nxt.rdata[15:0] = ctrl2_view;
          itc_pkg::ADDR_FLAGS0: state_nxt.rdata[15:0] = state_r.flags0 & itc_pkg::FLAGS0_MASK;
          itc_pkg::ADDR_ENABLE0: state_nxt.rdata[15:0] = state_r.enable0 & itc_pkg::FLAGS0_MASK;
          itc_pkg::ADDR_PRIO: state_nxt.rdata[PRIO_W-1:0] = state_r.prio;
          default: state_nxt.rdata = 32'h0000_0000;
        endcase
      end
    end

    if (do_write)
    begin
      unique case (avs_address_i)
        itc_pkg::ADDR_CTRL1:
          state_nxt.ctrl1 = ((state_r.ctrl1 & ~wmask) | (wdata & wmask)) & itc_pkg::CTRL1_MASK;
        itc_pkg::ADDR_CTRL2:
        begin
          if (avs_byteenable_i[1])
            state_nxt.alt_vec = wdata[itc_pkg::C2_ALT_VEC];
          if (avs_byteenable_i[0])
            state_nxt.edge_pol = wdata[itc_pkg::C2_EDGE_POL +: EXT_N];
        end
        itc_pkg::ADDR_FLAGS0:
          state_nxt.flags0 = ((state_r.flags0 & ~wmask) | (wdata & wmask)) & itc_pkg::FLAGS0_MASK;
        itc_pkg::ADDR_ENABLE0:
          state_nxt.enable0 = ((state_r.enable0 & ~wmask) | (wdata & wmask)) & itc_pkg::FLAGS0_MASK;
        itc_pkg::ADDR_PRIO:
          if (avs_byteenable_i[0])
            state_nxt.prio = wdata[PRIO_W-1:0];
        default:
        begin
        end
      endcase
    end

    // Hardware sets are applied after the write, so they win a tie.
    state_nxt.ctrl1 = state_nxt.ctrl1 | ctrl1_set;
    state_nxt.flags0 = state_nxt.flags0 | flags0_set;

    state_nxt.ext_prev = external_irq_inputs_i;
    state_nxt.ext_edge = ext_edge;

    // Only the push and pop instructions touch the shadows; no bus path.
    state_nxt.restore = shadow_pop_i;
    if (shadow_push_i)
    begin
      state_nxt.sh_status = status_i;
      state_nxt.sh_wregs = wregs_i;
    end

    // Request and wake leave on the same edge, so the core resumes
    // straight into the service routine.
    state_nxt.irq = pending;
    state_nxt.wake = pending & (sleep_i | idle_i);
    state_nxt.trap_pend = |(state_r.ctrl1 & itc_pkg::CTRL1_MASK &
      ~(16'h0001 << itc_pkg::C1_NEST_DIS) & ~(16'h0007 << itc_pkg::C1_COV_TE));
  end

  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_r <= '0;
      state_r.wait_n <= 1'b1;
      state_r.ctrl1 <= itc_pkg::RESET_VAL;
      state_r.flags0 <= itc_pkg::RESET_VAL;
      state_r.enable0 <= itc_pkg::RESET_VAL;
      state_r.prio <= PRIO_W'(itc_pkg::PRIO_RESET);
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  assign avs_readdata_o = state_r.rdata;
  assign avs_waitrequest_o = state_r.wait_n;
  assign shadow_status_o = state_r.sh_status;
  assign shadow_wregs_o = state_r.sh_wregs;
  assign shadow_restore_o = state_r.restore;
  assign ext_edge_o = state_r.ext_edge;
  assign irq_request_o = state_r.irq;
  assign wake_o = state_r.wake;
  assign alt_vector_select_o = state_r.alt_vec;
  assign nesting_disable_o = state_r.ctrl1[itc_pkg::C1_NEST_DIS];
  assign trap_pending_o = state_r.trap_pend;

endmodule : itc_top
`default_nettype wire

// file: tb/itc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module itc_core_model (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic sleep_req_i,
  input wire logic wake_i,
  output logic sleep_o,
  output itc_pkg::itc_status_s status_o,
  output itc_pkg::itc_wregs_t wregs_o
);
  logic [15:0] cnt_r;
  // Context moves every cycle so a late or stale shadow capture shows up.
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      cnt_r <= 16'h0000;
      sleep_o <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
      if (wake_i)
        sleep_o <= 1'b0;
      else if (sleep_req_i)
        sleep_o <= 1'b1;
    end
  end
  assign status_o = itc_pkg::itc_status_s'(cnt_r[4:0]);
  assign wregs_o = {~cnt_r, cnt_r ^ 16'h5A5A, cnt_r + 16'h0003, cnt_r};
endmodule : itc_core_model
`default_nettype wire

// file: tb/itc_props.sv
`timescale 1ns/100ps
`default_nettype none
module itc_props #(
  parameter int EXT_N = 3
) (
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [EXT_N-1:0] external_irq_inputs_i,
  input wire logic shadow_push_i,
  input wire logic shadow_pop_i,
  input wire itc_pkg::itc_status_s status_i,
  input wire itc_pkg::itc_wregs_t wregs_i,
  input wire itc_pkg::itc_status_s shadow_status_o,
  input wire itc_pkg::itc_wregs_t shadow_wregs_o,
  input wire logic shadow_restore_o,
  input wire logic [EXT_N-1:0] ext_edge_o,
  input wire logic irq_request_o,
  input wire logic wake_o
);
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_ack;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  property p_ack;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> s_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("bus answer timing wrong");
  property p_rdh;
    !(avs_read_i || avs_write_i) |=> $stable(avs_readdata_o);
  endproperty
  a_rdh: assert property (p_rdh) else $error("read data moved while idle");
  property p_rhi;
    avs_readdata_o[31:16] == 16'h0000;
  endproperty
  a_rhi: assert property (p_rhi) else $error("upper read data not zero");
  property p_push;
    shadow_push_i |=> shadow_status_o == $past(status_i) && shadow_wregs_o == $past(wregs_i);
  endproperty
  a_push: assert property (p_push) else $error("shadow not loaded");
  property p_keep;
    !shadow_push_i |=> $stable(shadow_wregs_o) && $stable(shadow_status_o);
  endproperty
  a_keep: assert property (p_keep) else $error("shadow changed without push");
  property p_pop;
    shadow_restore_o == $past(shadow_pop_i);
  endproperty
  a_pop: assert property (p_pop) else $error("restore not tied to pop");
  property p_lvl;
    $stable(external_irq_inputs_i) |=> ext_edge_o == '0;
  endproperty
  a_lvl: assert property (p_lvl) else $error("edge seen on static input");
  property p_wake;
    wake_o |-> irq_request_o;
  endproperty
  a_wake: assert property (p_wake) else $error("wake without request");
endmodule : itc_props
`default_nettype wire

// file: tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [4:0] adr = 5'h00;
  logic rd = 1'b0, wr = 1'b0, dis = 1'b0, insvc = 1'b0, push = 1'b0, pop = 1'b0, slp_req = 1'b0;
  logic [31:0] wdat = 32'h0, q, rdat;
  itc_pkg::itc_trap_ev_s te = '0;
  logic [15:0] pe = 16'h0000;
  logic [2:0] ext = 3'h0, edg, s;
  logic [3:0] cprio = 4'h0;
  logic wt, rest, irq, wake, alt, nest, trp, slp;
  itc_pkg::itc_status_s stat, sh_st;
  itc_pkg::itc_wregs_t wregs, sh_w;
  int mismatches = 0, cmp_count = 0;
  logic [15:0] tx [9] = '{16'h4010, 16'h2010, 16'h1010, 16'h0810, 16'h0090, 16'h0050,
    16'h0008, 16'h0004, 16'h0002};
  always #20 clk_i = ~clk_i;
  itc_core_model i_itc_core_model (.clk_i(clk_i), .reset_i(reset_i), .sleep_req_i(slp_req),
    .wake_i(wake), .sleep_o(slp), .status_o(stat), .wregs_o(wregs));
  itc_top i_itc_top (.clk_i(clk_i), .reset_i(reset_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wt), .external_irq_inputs_i(ext), .periph_events_i(pe),
    .trap_events_i(te), .irq_disable_active_i(dis), .core_priority_i(cprio),
    .in_service_i(insvc), .sleep_i(slp), .idle_i(1'b0), .shadow_push_i(push),
    .shadow_pop_i(pop), .status_i(stat), .wregs_i(wregs), .shadow_status_o(sh_st),
    .shadow_wregs_o(sh_w), .shadow_restore_o(rest), .ext_edge_o(edg), .irq_request_o(irq),
    .wake_o(wake), .alt_vector_select_o(alt), .nesting_disable_o(nest), .trap_pending_o(trp));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Request is held until waitrequest is sampled low, as the bus demands.
  task automatic acc(input logic [4:0] a, input logic we, input logic [15:0] d);
    @(posedge clk_i);
    adr <= a;
    wr <= we;
    rd <= !we;
    wdat <= {16'h0000, d};
    do
    begin
      @(posedge clk_i);
    end while (wt !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : acc
  task automatic rc(input logic [4:0] a, input logic [15:0] e);
    acc(a, 1'b0, 16'h0000);
    chk($sformatf("reg%h", a), {16'h0000, e}, q);
  endtask : rc
  task automatic step(input logic [2:0] v);
    s = 3'h0;
    @(posedge clk_i);
    ext <= v;
    repeat (3)
    begin
      @(posedge clk_i);
      s = s | edg;
    end
  endtask : step
  task automatic close_out;
    $display("mismatches %0d compares %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out
  initial
  begin
    #2000000;
    mismatches++;
    close_out();
  end
  initial
  begin
    repeat (20) @(posedge clk_i);
    reset_i <= 1'b0;
    rc(5'h00, 16'h0000);
    rc(5'h04, 16'h0000);
    rc(5'h08, 16'h0000);
    dis <= 1'b1;
    slp_req <= 1'b1;
    acc(5'h00, 1'b1, 16'hFFFF);
    rc(5'h00, 16'hFFDE);
    acc(5'h04, 1'b1, 16'hFFFF);
    rc(5'h04, 16'hC007);
    chk("alt", 1, alt);
    chk("nest", 1, nest);
    acc(5'h08, 1'b1, 16'hFFFF);
    rc(5'h08, 16'h7FEF);
    acc(5'h14, 1'b1, 16'hFFFF);
    rc(5'h14, 16'h0000);
    dis <= 1'b0;
    acc(5'h04, 1'b1, 16'h0000);
    rc(5'h04, 16'h0000);
    chk("alt", 0, alt);
    acc(5'h08, 1'b1, 16'h0000);
    acc(5'h00, 1'b1, 16'h0000);
    te <= itc_pkg::itc_trap_ev_s'(9'h1E0);
    @(posedge clk_i);
    te <= '0;
    rc(5'h00, 16'h0000);
    for (int i = 0; i < 9; i++)
    begin
      acc(5'h00, 1'b1, 16'h0700);
      te <= itc_pkg::itc_trap_ev_s'(9'h100 >> i);
      @(posedge clk_i);
      te <= '0;
      rc(5'h00, tx[i] | 16'h0700);
    end
    chk("trap", 1, trp);
    acc(5'h00, 1'b1, 16'h0000);
    pe <= 16'hFFFF;
    @(posedge clk_i);
    pe <= 16'h0000;
    rc(5'h08, 16'h7FEE);
    chk("trap", 0, trp);
    acc(5'h08, 1'b1, 16'h0000);
    for (int p = 0; p < 2; p++)
    begin
      acc(5'h04, 1'b1, p ? 16'h0007 : 16'h0000);
      step(3'h7);
      chk("rise", p ? 3'h0 : 3'h7, s);
      step(3'h7);
      chk("level", 3'h0, s);
      step(3'h0);
      chk("fall", p ? 3'h7 : 3'h0, s);
    end
    rc(5'h08, 16'h0001);
    chk("asleep", 1, slp);
    slp_req <= 1'b0;
    acc(5'h0C, 1'b1, 16'h0001);
    repeat (4) @(posedge clk_i);
    chk("irq", 1, irq);
    chk("woken", 0, slp);
    insvc <= 1'b1;
    acc(5'h00, 1'b1, 16'h8000);
    repeat (3) @(posedge clk_i);
    chk("nested", 0, irq);
    acc(5'h00, 1'b1, 16'h0000);
    repeat (3) @(posedge clk_i);
    chk("nested", 1, irq);
    cprio <= 4'h4;
    repeat (3) @(posedge clk_i);
    chk("prio", 0, irq);
    cprio <= 4'h3;
    repeat (3) @(posedge clk_i);
    chk("prio", 1, irq);
    push <= 1'b1;
    repeat (2) @(posedge clk_i);
    push <= 1'b0;
    pop <= 1'b1;
    @(posedge clk_i);
    pop <= 1'b0;
    @(posedge clk_i);
    chk("restore", 1, rest);
    repeat (3) @(posedge clk_i);
    close_out();
  end
endmodule : testbench
bind itc_top itc_props #(.EXT_N(EXT_N)) i_itc_props (.*);
`default_nettype wire
